// ===== design/sc_ir_pkg.sv
/*
   constants, register map and state codes for the smart-card / infrared serial port.
   assumes an APB slave with byte addresses on an 8-bit paddr.
*/
package sc_ir_pkg;

   // ==========================================================
   // register byte offsets
   localparam logic [7:0] OFS_COMMAND = 8'h00;
   localparam logic [7:0] OFS_CONFIG = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h14;
   localparam logic [7:0] OFS_RX_HOLD = 8'h18;
   localparam logic [7:0] OFS_TX_HOLD = 8'h1C;
   localparam logic [7:0] OFS_BAUD = 8'h20;
   localparam logic [7:0] OFS_ERR_COUNT = 8'h44;

   // ==========================================================
   // operating modes
   localparam logic [3:0] MODE_NORMAL = 4'h0;
   localparam logic [3:0] MODE_T0 = 4'h4;
   localparam logic [3:0] MODE_T1 = 4'h5;
   localparam logic [3:0] MODE_IR = 4'h8;

   // ==========================================================
   // config register fields
   localparam int CFG_MODE_LSB = 0;
   localparam int CFG_PARITY_LSB = 9;
   localparam int CFG_TWO_STOP_BIT = 12;
   localparam int CFG_MSB_FIRST_BIT = 16;
   localparam int CFG_NACK_INHIBIT_BIT = 20;
   localparam int CFG_LIMIT_NACK_BIT = 21;
   localparam int CFG_MAX_ITER_LSB = 24;
   localparam logic [2:0] PARITY_EVEN = 3'h0;
   localparam logic [2:0] PARITY_ODD = 3'h1;
   localparam logic [2:0] PARITY_NONE = 3'h4;

   // ==========================================================
   // command register bits
   localparam int CMD_RX_EN = 4;
   localparam int CMD_RX_DIS = 5;
   localparam int CMD_TX_EN = 6;
   localparam int CMD_TX_DIS = 7;
   localparam int CMD_CLR_STATUS = 8;
   localparam int CMD_CLR_REPEAT = 10;
   localparam int CMD_CLR_NACK_INHIBIT = 14;

   // ==========================================================
   // status register bits
   localparam int ST_RX_READY = 0;
   localparam int ST_TX_READY = 1;
   localparam int ST_PARITY_ERR = 5;
   localparam int ST_TX_EMPTY = 9;
   localparam int ST_REPEAT = 10;
   localparam int ST_NACK_INHIBIT = 13;

   // ==========================================================
   // bit timing in sample ticks of 16 per bit, bit and stop counts, and the error count limit
   localparam logic [3:0] SUB_LAST = 4'hF;
   localparam logic [3:0] SUB_MID = 4'h7;
   localparam logic [3:0] SUB_FIRST_RX = 4'h1;
   localparam logic [3:0] IR_PULSE_SUBS = 4'h3;
   localparam logic [2:0] DATA_LAST = 3'h7;
   localparam logic [1:0] GUARD_BITS_T0 = 2'h2;
   localparam logic [1:0] STOP_ONE = 2'h1;
   localparam logic [1:0] STOP_TWO = 2'h2;
   localparam logic [7:0] ERR_COUNT_MAX = 8'hFF;

   // ==========================================================
   // state machines
   typedef enum logic [4:0] {
      TX_IDLE = 5'b00001,
      TX_START = 5'b00010,
      TX_DATA = 5'b00100,
      TX_PARITY = 5'b01000,
      TX_STOP = 5'b10000
   } tx_state_e;

   typedef enum logic [5:0] {
      RX_IDLE = 6'b000001,
      RX_START = 6'b000010,
      RX_DATA = 6'b000100,
      RX_PARITY = 6'b001000,
      RX_NACK = 6'b010000,
      RX_STOP = 6'b100000
   } rx_state_e;

endpackage

// ===== design/sample_tick.sv
/*
   sample tick generator: one pclk pulse every divisor clocks.
   assumes divisor is stable from the register file; zero stops the ticks.
*/
`timescale 1ns/1ps

module sample_tick
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [15:0] divisor,
   output logic tick
);

   typedef struct packed {
      logic [15:0] count;
      logic tick;
   } tick_state_s;

   tick_state_s s_reg;
   tick_state_s s_next;

   always_comb
   begin
      s_next = s_reg;
      s_next.tick = 1'b0;
      if (divisor == 16'h0000)
      begin
         s_next.count = 16'h0000;
      end
      else if (s_reg.count >= divisor - 16'h0001)
      begin
         s_next.count = 16'h0000;
         s_next.tick = 1'b1;
      end
      else
      begin
         s_next.count = s_reg.count + 16'h0001;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s_reg <= '0;
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   assign tick = s_reg.tick;

endmodule // sample_tick

// ===== design/sc_ir_uart.sv
/*
   smart-card (T=0, T=1) and infrared serial port with an APB register file.
   assumes async pins txd_in and rxd_in; the bench resolves the shared io line.
*/
// Our own choices: the address map and the APB slave port.
`timescale 1ns/1ps

module sc_ir_uart
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic txd_in,
   output logic txd_out,
   output logic txd_oe,
   input wire logic rxd_in,
   output logic sck_out
);

   typedef struct packed {
      logic [3:0] mode;
      logic [2:0] parity_type_field;
      logic two_stop;
      logic msb_first_select;
      logic nack_inhibit;
      logic limit_successive_nack;
      logic [2:0] max_iter;
      logic [15:0] divisor;
      logic rx_on;
      logic tx_on;
      logic [7:0] tx_hold;
      logic tx_hold_full;
      logic [7:0] rx_hold;
      logic receive_ready_flag;
      logic parity_error_flag;
      logic repeat_flag;
      logic nack_inhibit_flag;
      logic [7:0] error_count_field;
      sc_ir_pkg::tx_state_e tx_st;
      logic [3:0] tx_sub;
      logic [2:0] tx_idx;
      logic [1:0] tx_stops;
      logic [7:0] tx_char;
      logic [7:0] tx_shift;
      logic [2:0] tx_rep;
      logic tx_nacked;
      sc_ir_pkg::rx_state_e rx_st;
      logic [3:0] rx_sub;
      logic [2:0] rx_idx;
      logic [7:0] rx_shift;
      logic rx_parity;
      logic [2:0] rx_nacks;
      logic sck;
      logic io_meta;
      logic io_sync;
      logic rxd_meta;
      logic rxd_sync;
      logic pin_out;
      logic pin_oe;
      logic [31:0] rdata;
   } state_s;

   state_s s_reg;
   state_s s_next;
   logic tick;
   logic smart;
   logic t0;
   logic ir;
   logic [2:0] parity_mode;
   logic parity_on;
   logic [1:0] stop_bits;
   logic rx_line;
   logic wr_acc;
   logic rd_acc;
   logic setup;
   logic mapped;

   // ==========================================================
   // sample tick
   sample_tick u_tick
   (
      .pclk(pclk),
      .presetn(presetn),
      .divisor(s_reg.divisor),
      .tick(tick)
   );

   // ==========================================================
   // mode decode
   assign t0 = (s_reg.mode == sc_ir_pkg::MODE_T0);
   assign smart = t0 || (s_reg.mode == sc_ir_pkg::MODE_T1);
   assign ir = (s_reg.mode == sc_ir_pkg::MODE_IR);
   assign parity_mode = smart ? sc_ir_pkg::PARITY_EVEN : s_reg.parity_type_field;
   assign parity_on = (parity_mode == sc_ir_pkg::PARITY_EVEN)
      || (parity_mode == sc_ir_pkg::PARITY_ODD);
   assign stop_bits = t0 ? sc_ir_pkg::GUARD_BITS_T0
      : (smart || !s_reg.two_stop) ? sc_ir_pkg::STOP_ONE
      : sc_ir_pkg::STOP_TWO;
   assign rx_line = smart ? s_reg.io_sync : s_reg.rxd_sync;

   // ==========================================================
   // apb decode
   assign setup = psel && !penable;
   assign wr_acc = psel && penable && pwrite;
   assign rd_acc = psel && penable && !pwrite;
   assign mapped = (paddr == sc_ir_pkg::OFS_COMMAND) || (paddr == sc_ir_pkg::OFS_CONFIG)
      || (paddr == sc_ir_pkg::OFS_STATUS) || (paddr == sc_ir_pkg::OFS_RX_HOLD)
      || (paddr == sc_ir_pkg::OFS_TX_HOLD) || (paddr == sc_ir_pkg::OFS_BAUD)
      || (paddr == sc_ir_pkg::OFS_ERR_COUNT);
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;

   localparam logic [1:0] GUARD_FIRST = sc_ir_pkg::GUARD_BITS_T0 - 2'h1;

   // ==========================================================
   // next state
   always_comb
   begin
      logic tx_bit;
      logic tx_level;
      logic tx_drive;
      logic perr;
      s_next = s_reg;
      tx_bit = 1'b1;
      tx_level = 1'b1;
      tx_drive = 1'b0;
      perr = 1'b0;

      // pin synchronisers
      s_next.io_meta = txd_in;
      s_next.io_sync = s_reg.io_meta;
      s_next.rxd_meta = rxd_in;
      s_next.rxd_sync = s_reg.rxd_meta;

      // card clock
      if (smart && tick)
      begin
         s_next.sck = !s_reg.sck;
      end
      else if (!smart)
      begin
         s_next.sck = 1'b0;
      end

      // read data, latched in the setup phase
      if (setup)
      begin
         s_next.rdata = 32'h0000_0000;
         case (paddr)
            sc_ir_pkg::OFS_CONFIG:
            begin
               s_next.rdata[sc_ir_pkg::CFG_MODE_LSB +: 4] = s_reg.mode;
               s_next.rdata[sc_ir_pkg::CFG_PARITY_LSB +: 3] = s_reg.parity_type_field;
               s_next.rdata[sc_ir_pkg::CFG_TWO_STOP_BIT] = s_reg.two_stop;
               s_next.rdata[sc_ir_pkg::CFG_MSB_FIRST_BIT] = s_reg.msb_first_select;
               s_next.rdata[sc_ir_pkg::CFG_NACK_INHIBIT_BIT] = s_reg.nack_inhibit;
               s_next.rdata[sc_ir_pkg::CFG_LIMIT_NACK_BIT] = s_reg.limit_successive_nack;
               s_next.rdata[sc_ir_pkg::CFG_MAX_ITER_LSB +: 3] = s_reg.max_iter;
            end
            sc_ir_pkg::OFS_STATUS:
            begin
               s_next.rdata[sc_ir_pkg::ST_RX_READY] = s_reg.receive_ready_flag;
               s_next.rdata[sc_ir_pkg::ST_TX_READY] = !s_reg.tx_hold_full;
               s_next.rdata[sc_ir_pkg::ST_PARITY_ERR] = s_reg.parity_error_flag;
               s_next.rdata[sc_ir_pkg::ST_TX_EMPTY] = !s_reg.tx_hold_full
                  && (s_reg.tx_st == sc_ir_pkg::TX_IDLE);
               s_next.rdata[sc_ir_pkg::ST_REPEAT] = s_reg.repeat_flag;
               s_next.rdata[sc_ir_pkg::ST_NACK_INHIBIT] = s_reg.nack_inhibit_flag;
            end
            sc_ir_pkg::OFS_RX_HOLD:
               s_next.rdata[7:0] = s_reg.rx_hold;
            sc_ir_pkg::OFS_BAUD:
               s_next.rdata[15:0] = s_reg.divisor;
            sc_ir_pkg::OFS_ERR_COUNT:
               s_next.rdata[7:0] = s_reg.error_count_field;
            default:
               s_next.rdata = 32'h0000_0000;
         endcase
      end

      // read side effects; later hardware sets override these clears
      if (rd_acc && paddr == sc_ir_pkg::OFS_RX_HOLD)
      begin
         s_next.receive_ready_flag = 1'b0;
      end
      if (rd_acc && paddr == sc_ir_pkg::OFS_ERR_COUNT)
      begin
         s_next.error_count_field = 8'h00;
      end

      // register writes
      if (wr_acc)
      begin
         case (paddr)
            sc_ir_pkg::OFS_COMMAND:
            begin
               if (pwdata[sc_ir_pkg::CMD_RX_EN])
                  s_next.rx_on = 1'b1;
               if (pwdata[sc_ir_pkg::CMD_RX_DIS])
                  s_next.rx_on = 1'b0;
               if (pwdata[sc_ir_pkg::CMD_TX_EN])
                  s_next.tx_on = 1'b1;
               if (pwdata[sc_ir_pkg::CMD_TX_DIS])
                  s_next.tx_on = 1'b0;
               if (pwdata[sc_ir_pkg::CMD_CLR_STATUS])
                  s_next.parity_error_flag = 1'b0;
               if (pwdata[sc_ir_pkg::CMD_CLR_REPEAT])
                  s_next.repeat_flag = 1'b0;
               if (pwdata[sc_ir_pkg::CMD_CLR_NACK_INHIBIT])
                  s_next.nack_inhibit_flag = 1'b0;
            end
            sc_ir_pkg::OFS_CONFIG:
            begin
               s_next.mode = pwdata[sc_ir_pkg::CFG_MODE_LSB +: 4];
               s_next.parity_type_field = pwdata[sc_ir_pkg::CFG_PARITY_LSB +: 3];
               s_next.two_stop = pwdata[sc_ir_pkg::CFG_TWO_STOP_BIT];
               s_next.msb_first_select = pwdata[sc_ir_pkg::CFG_MSB_FIRST_BIT];
               s_next.nack_inhibit = pwdata[sc_ir_pkg::CFG_NACK_INHIBIT_BIT];
               s_next.limit_successive_nack = pwdata[sc_ir_pkg::CFG_LIMIT_NACK_BIT];
               s_next.max_iter = pwdata[sc_ir_pkg::CFG_MAX_ITER_LSB +: 3];
            end
            sc_ir_pkg::OFS_TX_HOLD:
            begin
               s_next.tx_hold = pwdata[7:0];
               s_next.tx_hold_full = 1'b1;
            end
            sc_ir_pkg::OFS_BAUD:
               s_next.divisor = pwdata[15:0];
            default:
               s_next.divisor = s_next.divisor;
         endcase
      end

      // ==========================================================
      // transmitter
      tx_bit = s_reg.msb_first_select ? s_reg.tx_shift[7] : s_reg.tx_shift[0];
      if (s_reg.tx_st != sc_ir_pkg::TX_IDLE && tick)
      begin
         s_next.tx_sub = s_reg.tx_sub + 4'h1;
      end
      case (s_reg.tx_st)
         sc_ir_pkg::TX_IDLE:
         begin
            if (s_reg.tx_on && s_reg.tx_hold_full && !wr_acc)
            begin
               s_next.tx_char = s_reg.tx_hold;
               s_next.tx_shift = s_reg.tx_hold;
               s_next.tx_hold_full = 1'b0;
               s_next.tx_rep = 3'h0;
               s_next.tx_sub = 4'h0;
               s_next.tx_st = sc_ir_pkg::TX_START;
            end
         end
         sc_ir_pkg::TX_START:
         begin
            tx_level = 1'b0;
            tx_drive = 1'b1;
            if (tick && s_reg.tx_sub == sc_ir_pkg::SUB_LAST)
            begin
               s_next.tx_idx = 3'h0;
               s_next.tx_st = sc_ir_pkg::TX_DATA;
            end
         end
         sc_ir_pkg::TX_DATA:
         begin
            tx_level = tx_bit;
            tx_drive = 1'b1;
            if (tick && s_reg.tx_sub == sc_ir_pkg::SUB_LAST)
            begin
               s_next.tx_shift = s_reg.msb_first_select ? {s_reg.tx_shift[6:0], 1'b0}
                  : {1'b0, s_reg.tx_shift[7:1]};
               s_next.tx_idx = s_reg.tx_idx + 3'h1;
               s_next.tx_stops = stop_bits - 2'h1;
               s_next.tx_nacked = 1'b0;
               if (s_reg.tx_idx == sc_ir_pkg::DATA_LAST)
                  s_next.tx_st = parity_on ? sc_ir_pkg::TX_PARITY : sc_ir_pkg::TX_STOP;
            end
         end
         sc_ir_pkg::TX_PARITY:
         begin
            tx_level = (^s_reg.tx_char) ^ (parity_mode == sc_ir_pkg::PARITY_ODD);
            tx_drive = 1'b1;
            if (tick && s_reg.tx_sub == sc_ir_pkg::SUB_LAST)
               s_next.tx_st = sc_ir_pkg::TX_STOP;
         end
         sc_ir_pkg::TX_STOP:
         begin
            tx_drive = !t0;
            if (t0 && tick && s_reg.tx_sub == sc_ir_pkg::SUB_MID && !s_reg.tx_nacked
               && s_reg.tx_stops == GUARD_FIRST && !rx_line)
            begin
               s_next.tx_nacked = 1'b1;
               s_next.tx_stops = sc_ir_pkg::GUARD_BITS_T0;
            end
            if (tick && s_reg.tx_sub == sc_ir_pkg::SUB_LAST)
            begin
               if (s_reg.tx_stops != 2'h0)
               begin
                  s_next.tx_stops = s_reg.tx_stops - 2'h1;
               end
               else if (t0 && s_reg.tx_nacked && s_reg.max_iter != 3'h0
                  && s_reg.tx_rep != s_reg.max_iter)
               begin
                  s_next.tx_rep = s_reg.tx_rep + 3'h1;
                  if (s_reg.tx_rep + 3'h1 == s_reg.max_iter)
                     s_next.repeat_flag = 1'b1;
                  s_next.tx_shift = s_reg.tx_char;
                  s_next.tx_st = sc_ir_pkg::TX_START;
               end
               else
               begin
                  if (!s_reg.tx_nacked)
                     s_next.tx_rep = 3'h0;
                  s_next.tx_st = sc_ir_pkg::TX_IDLE;
               end
            end
         end
         default:
            s_next.tx_st = sc_ir_pkg::TX_IDLE;
      endcase

      // ==========================================================
      // receiver
      if (s_reg.rx_st != sc_ir_pkg::RX_IDLE && tick)
      begin
         s_next.rx_sub = s_reg.rx_sub + 4'h1;
      end
      case (s_reg.rx_st)
         sc_ir_pkg::RX_IDLE:
         begin
            if (s_reg.rx_on && tick && !rx_line)
            begin
               s_next.rx_sub = sc_ir_pkg::SUB_FIRST_RX;
               s_next.rx_st = sc_ir_pkg::RX_START;
            end
         end
         sc_ir_pkg::RX_START:
         begin
            if (tick && s_reg.rx_sub == sc_ir_pkg::SUB_MID && rx_line)
               s_next.rx_st = sc_ir_pkg::RX_IDLE;
            else if (tick && s_reg.rx_sub == sc_ir_pkg::SUB_LAST)
            begin
               s_next.rx_idx = 3'h0;
               s_next.rx_st = sc_ir_pkg::RX_DATA;
            end
         end
         sc_ir_pkg::RX_DATA:
         begin
            if (tick && s_reg.rx_sub == sc_ir_pkg::SUB_MID)
               s_next.rx_shift = s_reg.msb_first_select ? {s_reg.rx_shift[6:0], rx_line}
                  : {rx_line, s_reg.rx_shift[7:1]};
            if (tick && s_reg.rx_sub == sc_ir_pkg::SUB_LAST)
            begin
               s_next.rx_idx = s_reg.rx_idx + 3'h1;
               if (s_reg.rx_idx == sc_ir_pkg::DATA_LAST && parity_on)
                  s_next.rx_st = sc_ir_pkg::RX_PARITY;
               else if (s_reg.rx_idx == sc_ir_pkg::DATA_LAST)
               begin
                  s_next.rx_hold = s_reg.rx_shift;
                  s_next.receive_ready_flag = 1'b1;
                  s_next.rx_st = sc_ir_pkg::RX_STOP;
               end
            end
         end
         sc_ir_pkg::RX_PARITY:
         begin
            if (tick && s_reg.rx_sub == sc_ir_pkg::SUB_MID)
               s_next.rx_parity = rx_line;
            if (tick && s_reg.rx_sub == sc_ir_pkg::SUB_LAST)
            begin
               perr = s_reg.rx_parity
                  != ((^s_reg.rx_shift) ^ (parity_mode == sc_ir_pkg::PARITY_ODD));
               s_next.rx_st = sc_ir_pkg::RX_STOP;
               if (!perr)
               begin
                  s_next.rx_hold = s_reg.rx_shift;
                  s_next.receive_ready_flag = 1'b1;
                  s_next.rx_nacks = 3'h0;
               end
               else if (t0 && s_reg.nack_inhibit)
               begin
                  s_next.rx_hold = s_reg.rx_shift;
                  s_next.nack_inhibit_flag = 1'b1;
               end
               else if (t0 && s_reg.limit_successive_nack
                  && s_reg.rx_nacks == s_reg.max_iter)
               begin
                  s_next.rx_hold = s_reg.rx_shift;
                  s_next.receive_ready_flag = 1'b1;
                  s_next.repeat_flag = 1'b1;
                  s_next.rx_nacks = 3'h0;
               end
               else if (t0)
               begin
                  s_next.parity_error_flag = 1'b1;
                  s_next.rx_nacks = s_reg.rx_nacks + 3'h1;
                  s_next.rx_st = sc_ir_pkg::RX_NACK;
               end
               else
               begin
                  s_next.rx_hold = s_reg.rx_shift;
                  s_next.receive_ready_flag = 1'b1;
                  s_next.parity_error_flag = 1'b1;
               end
               if (perr && s_next.error_count_field != sc_ir_pkg::ERR_COUNT_MAX)
                  s_next.error_count_field = s_next.error_count_field + 8'h01;
               else if (perr)
                  s_next.error_count_field = sc_ir_pkg::ERR_COUNT_MAX;
            end
         end
         sc_ir_pkg::RX_NACK:
         begin
            if (tick && s_reg.rx_sub == sc_ir_pkg::SUB_LAST)
               s_next.rx_st = sc_ir_pkg::RX_STOP;
         end
         sc_ir_pkg::RX_STOP:
         begin
            if (tick && s_reg.rx_sub == sc_ir_pkg::SUB_LAST)
               s_next.rx_st = sc_ir_pkg::RX_IDLE;
         end
         default:
            s_next.rx_st = sc_ir_pkg::RX_IDLE;
      endcase

      // ==========================================================
      // pin drive
      if (s_reg.rx_st == sc_ir_pkg::RX_NACK)
      begin
         s_next.pin_out = 1'b0;
         s_next.pin_oe = 1'b1;
      end
      else if (ir)
      begin
         s_next.pin_out = tx_level || (s_reg.tx_sub >= sc_ir_pkg::IR_PULSE_SUBS);
         s_next.pin_oe = 1'b1;
      end
      else
      begin
         s_next.pin_out = tx_level;
         s_next.pin_oe = tx_drive || !smart;
      end
   end

   // ==========================================================
   // state register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s_reg <= '0;
         s_reg.tx_st <= sc_ir_pkg::TX_IDLE;
         s_reg.rx_st <= sc_ir_pkg::RX_IDLE;
         s_reg.parity_type_field <= sc_ir_pkg::PARITY_NONE;
         s_reg.io_meta <= 1'b1;
         s_reg.io_sync <= 1'b1;
         s_reg.rxd_meta <= 1'b1;
         s_reg.rxd_sync <= 1'b1;
         s_reg.pin_out <= 1'b1;
         s_reg.pin_oe <= 1'b1;
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   assign prdata = s_reg.rdata;
   assign txd_out = s_reg.pin_out;
   assign txd_oe = s_reg.pin_oe;
   assign sck_out = s_reg.sck;

endmodule // sc_ir_uart

// ===== verif/sc_ir_uart_sva.sv
/* bus and io-pin checks.
   assumes bind onto sc_ir_uart. */
`timescale 1ns/1ps
module sc_ir_uart_sva
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic txd_out,
   input wire logic txd_oe
);
   // ==========================================================
   // relations
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire acc = psel && penable;
   wire rd = acc && !pwrite;
   property p_ready; acc |-> pready; endproperty
   a_ready: assert property (p_ready) else $error("ready low");
   property p_err; pslverr |-> acc; endproperty
   a_err: assert property (p_err) else $error("stray error");
   property p_map; acc && paddr == sc_ir_pkg::OFS_CONFIG |-> !pslverr; endproperty
   a_map: assert property (p_map) else $error("mapped error");
   property p_unmap; acc && paddr == 8'h08 |-> pslverr; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped ok");
   property p_rd0; rd && pslverr |-> prdata == 32'h0000_0000; endproperty
   a_rd0: assert property (p_rd0) else $error("unmapped data");
   property p_cnt; rd && paddr == sc_ir_pkg::OFS_ERR_COUNT |-> prdata[31:8] == 0; endproperty
   a_cnt: assert property (p_cnt) else $error("count wide");
   property p_guard; $fell(txd_oe) |=> !txd_oe [*8]; endproperty
   a_guard: assert property (p_guard) else $error("short release");
   property p_drive; $rose(txd_oe) |=> txd_oe [*8]; endproperty
   a_drive: assert property (p_drive) else $error("short drive");
   c_unmap: cover property (acc && pslverr);
   c_fall: cover property ($fell(txd_oe));
   c_rise: cover property ($rose(txd_oe));
endmodule // sc_ir_uart_sva
bind sc_ir_uart sc_ir_uart_sva sva_inst(.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .txd_out(txd_out), .txd_oe(txd_oe));

// ===== verif/card_model.sv
/* smart card on the io line, 16 clocks a bit.
   assumes divisor 1; line has a pull-up. */
`timescale 1ns/1ps
module card_model
(
   input wire logic pclk,
   input wire logic txd_out,
   input wire logic txd_oe,
   output logic io_line
);
   // ==========================================================
   // line and receive side
   localparam int BIT = 16;
   logic drv = 0, dv = 1, busy = 0, nacked = 0;
   logic [7:0] got = 0;
   int left = 0, seen = 0;
   assign io_line = txd_oe ? txd_out : (drv ? dv : 1'b1);
   always
   begin
      @(posedge pclk);
      if (txd_oe && !txd_out && !busy)
      begin
         repeat (BIT / 2) @(posedge pclk);
         for (int i = 0; i < 8; i++)
         begin
            repeat (BIT) @(posedge pclk);
            got[i] = io_line;
         end
         repeat (BIT + BIT / 2) @(posedge pclk);
         seen++;
         if (left > 0)
         begin
            left--;
            drv <= 1;
            dv <= 0;
            repeat (BIT) @(posedge pclk);
            drv <= 0;
         end
         repeat (BIT) @(posedge pclk);
      end
   end
   task automatic send(input logic [7:0] b, input logic bad);
      logic [8:0] f;
      f = {(^b) ^ bad, b};
      busy = 1;
      drv <= 1;
      dv <= 0;
      repeat (BIT) @(posedge pclk);
      for (int i = 0; i < 9; i++)
      begin
         dv <= f[i];
         repeat (BIT) @(posedge pclk);
      end
      drv <= 0;
      repeat (BIT / 2) @(posedge pclk);
      nacked = !io_line;
      repeat (3 * BIT) @(posedge pclk);
      busy = 0;
   endtask
endmodule // card_model

// ===== verif/tb.sv
/* bench for the serial port.
   assumes card_model on the io line, divisor 1. */
`timescale 1ns/1ps
module tb;
   // ==========================================================
   // bench
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, rxd_in = 1;
   logic [7:0] paddr = 0;
   logic [31:0] pwdata = 0, rdata, prdata;
   logic pready, pslverr, txd_out, txd_oe, sck_out, io_line;
   int errors = 0, check_count = 0, lows;
   always #2.5 pclk = ~pclk;
   sc_ir_uart sc_ir_uart_inst(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .txd_in(io_line), .txd_out(txd_out), .txd_oe(txd_oe),
      .rxd_in(rxd_in), .sck_out(sck_out));
   card_model card_model_inst(.pclk(pclk), .txd_out(txd_out), .txd_oe(txd_oe),
      .io_line(io_line));
   task automatic close_out;
      $display("errors %0d checks %0d", errors, check_count);
      if (errors == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         errors++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      n = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 50)
      begin
         @(posedge pclk);
         n++;
      end
      if (n == 50)
      begin
         errors++;
         close_out();
      end
      rdata = prdata;
      psel <= 0;
      penable <= 0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      xfer(0, a, 0);
      chk(rdata, e);
   endtask
   task automatic rds(input int b, input logic e);
      xfer(0, sc_ir_pkg::OFS_STATUS, 0);
      chk(rdata[b], e);
   endtask
   initial
   begin
      repeat (6) @(posedge pclk);
      presetn <= 1;
      rd(sc_ir_pkg::OFS_CONFIG, 12'h800);
      rd(8'h08, 0);
      wr(sc_ir_pkg::OFS_CONFIG, 32'h0100_0004);
      wr(sc_ir_pkg::OFS_BAUD, 1);
      card_model_inst.left = 1;
      wr(sc_ir_pkg::OFS_COMMAND, 32'h0000_0040);
      wr(sc_ir_pkg::OFS_TX_HOLD, 8'hA5);
      repeat (440) @(posedge pclk) lows += sck_out;
      chk(lows, 220);
      chk(card_model_inst.got, 8'hA5);
      chk(card_model_inst.seen, 2);
      rds(sc_ir_pkg::ST_REPEAT, 1);
      wr(sc_ir_pkg::OFS_COMMAND, 32'h0000_0400);
      rds(sc_ir_pkg::ST_REPEAT, 0);
      wr(sc_ir_pkg::OFS_CONFIG, 32'h0001_0004);
      wr(sc_ir_pkg::OFS_TX_HOLD, 8'h01);
      repeat (230) @(posedge pclk);
      chk(card_model_inst.got, 8'h80);
      wr(sc_ir_pkg::OFS_COMMAND, 32'h0000_0090);
      wr(sc_ir_pkg::OFS_CONFIG, 32'h0000_0204);
      card_model_inst.send(8'h5A, 0);
      chk(card_model_inst.nacked, 0);
      rds(sc_ir_pkg::ST_RX_READY, 1);
      rd(sc_ir_pkg::OFS_RX_HOLD, 8'h5A);
      card_model_inst.send(8'h33, 1);
      chk(card_model_inst.nacked, 1);
      rds(sc_ir_pkg::ST_PARITY_ERR, 1);
      rds(sc_ir_pkg::ST_RX_READY, 0);
      rd(sc_ir_pkg::OFS_RX_HOLD, 8'h5A);
      rd(sc_ir_pkg::OFS_ERR_COUNT, 1);
      rd(sc_ir_pkg::OFS_ERR_COUNT, 0);
      wr(sc_ir_pkg::OFS_CONFIG, 32'h0010_0004);
      card_model_inst.send(8'h66, 1);
      chk(card_model_inst.nacked, 0);
      rds(sc_ir_pkg::ST_NACK_INHIBIT, 1);
      rds(sc_ir_pkg::ST_RX_READY, 0);
      rd(sc_ir_pkg::OFS_RX_HOLD, 8'h66);
      wr(sc_ir_pkg::OFS_COMMAND, 32'h0000_4100);
      rds(sc_ir_pkg::ST_NACK_INHIBIT, 0);
      wr(sc_ir_pkg::OFS_CONFIG, 32'h0000_0005);
      card_model_inst.send(8'h12, 1);
      rds(sc_ir_pkg::ST_PARITY_ERR, 1);
      wr(sc_ir_pkg::OFS_COMMAND, 32'h0000_0060);
      wr(sc_ir_pkg::OFS_CONFIG, 32'h0000_0808);
      wr(sc_ir_pkg::OFS_TX_HOLD, 8'hFE);
      lows = 0;
      repeat (192)
      begin
         @(posedge pclk);
         lows += (txd_out === 1'b0);
      end
      chk(lows, 6);
      close_out();
   end
endmodule // tb
